// ### logic/imro_pkg.sv
// Purpose: Shared constants for the indirect move and return execution block
// Assumes: One pclk cycle is one instruction cycle
// Notes:   APB byte offsets, command fields, status bit positions, reset values
package imro_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_ACC    = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PTR0   = 8'h0C;
    localparam logic [7:0] OFF_PTR1   = 8'h10;
    localparam logic [7:0] OFF_WIN0   = 8'h14;
    localparam logic [7:0] OFF_WIN1   = 8'h18;
    localparam logic [7:0] OFF_OPTION = 8'h1C;
    localparam logic [7:0] OFF_PWR    = 8'h20;
    localparam logic [7:0] OFF_IRQ    = 8'h24;
    localparam logic [7:0] OFF_PC     = 8'h28;
    localparam logic [7:0] OFF_STACK  = 8'h2C;
    localparam logic [7:0] OFF_DEPTH  = 8'h30;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_MODE_LSB = 4;
    localparam int CMD_SEL_BIT  = 6;
    localparam int CMD_BUSY_BIT = 31;

    // Operation codes
    localparam logic [3:0] OP_IDLE    = 4'h0;
    localparam logic [3:0] OP_WIN_RD  = 4'h1;
    localparam logic [3:0] OP_WIN_WR  = 4'h2;
    localparam logic [3:0] OP_OPTION  = 4'h3;
    localparam logic [3:0] OP_RESET   = 4'h4;
    localparam logic [3:0] OP_IRQ_RET = 4'h5;
    localparam logic [3:0] OP_RETURN  = 4'h6;

    // Pointer update modes
    localparam logic [1:0] MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
    localparam int MODE_DEC_BIT  = 0;
    localparam int MODE_POST_BIT = 1;

    // Bit positions
    localparam int STAT_C_BIT   = 0;
    localparam int STAT_DC_BIT  = 1;
    localparam int STAT_Z_BIT   = 2;
    localparam int IRQ_EN_BIT   = 7;
    localparam int RST_IND_BIT  = 2;

    // Reset values
    localparam logic [7:0]  OPTION_RST = 8'hFF;
    localparam logic [7:0]  PWR_RST    = 8'h04;
    localparam logic [7:0]  IRQ_RST    = 8'h00;
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [15:0] PTR_RST    = 16'h0000;
    localparam logic [14:0] PC_RST     = 15'h0000;

    // Sizes
    localparam int PC_W      = 15;
    localparam int STACK_N   = 16;
    localparam int SP_W      = 5;
    localparam int MEM_N     = 256;
    localparam int MEM_AW    = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_POP2 = 3'b100
    } imro_state_t;

endpackage

// ### logic/imro_ptr_unit.sv
// Purpose: Effective address and next value of an indirect pointer
// Assumes: Mode encoding pre-inc, pre-dec, post-inc, post-dec
// Notes:   Purely combinational, 16-bit wrap
module imro_ptr_unit (
    input  wire logic [15:0] ptr,
    input  wire logic [1:0]  mode,
    output logic      [15:0] addr,
    output logic      [15:0] ptr_next
);

    logic [15:0] step;

    always_comb begin
        // Wraps modulo 2^16, no flag output exists here, see RULE3 see RULE4
        if (mode[imro_pkg::MODE_DEC_BIT]) begin
            step = ptr - 16'h0001;
        end else begin
            step = ptr + 16'h0001;
        end
        // Pre modes move first, post modes move after the transfer, see RULE1
        addr     = mode[imro_pkg::MODE_POST_BIT] ? ptr : step;
        ptr_next = step;
    end

endmodule

// ### logic/imro_stack.sv
// Purpose: Sixteen-level hardware return stack
// Assumes: Push when full and pop when empty are ignored
// Notes:   Top reads zero when empty
module imro_stack (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       push,
    input  wire logic                       pop,
    input  wire logic                       flush,
    input  wire logic [imro_pkg::PC_W-1:0]  push_val,
    output logic      [imro_pkg::PC_W-1:0]  top,
    output logic      [imro_pkg::SP_W-1:0]  depth
);

    logic [imro_pkg::PC_W-1:0] mem [imro_pkg::STACK_N];
    logic [imro_pkg::SP_W-1:0] sp_q;
    logic [imro_pkg::SP_W-1:0] sp_d;
    logic                      full;
    logic                      empty;

    assign full  = (sp_q == imro_pkg::SP_W'(imro_pkg::STACK_N));
    assign empty = (sp_q == '0);
    assign depth = sp_q;
    assign top   = empty ? '0 : mem[sp_q[imro_pkg::SP_W-2:0] - 4'h1];

    always_comb begin
        sp_d = sp_q;
        if (flush) begin
            sp_d = '0;
        end else if (pop && !empty) begin
            sp_d = sp_q - 5'h01;
        end else if (push && !full) begin
            sp_d = sp_q + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= '0;
        end else begin
            sp_q <= sp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!flush && !pop && push && !full) begin
            mem[sp_q[imro_pkg::SP_W-2:0]] <= push_val;
        end
    end

endmodule

// ### logic/imro_core.sv
// Purpose: Executes indirect moves, option load, software reset and returns
// Assumes: APB slave with one wait state; one pclk is one instruction cycle
// Notes:   A command write starts one operation; commands while busy are dropped
//
// Overview of operation
// RULE1: An indirect move decodes its mode as pre-inc, pre-dec, post-inc or post-dec.
// RULE2: The indirect window has no storage and acts on the location its pointer holds.
// RULE3: The 16-bit indirect pointer wraps around modulo 2^16 when stepped.
// RULE4: Stepping the pointer during an indirect move changes no status flag.
// RULE5: The load-option operation copies the accumulator to option and keeps flags.
// RULE6: Software reset resets the core and clears the active-low reset indicator.
// RULE7: Interrupt return sets the global interrupt enable, bit 7 of irq control.
// RULE8: Interrupt return pops the stack into the program counter in two cycles.
// RULE9: Subroutine return pops the stack into the program counter in two cycles.
// RULE10: The idle operation takes one cycle and only advances the program counter.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
module imro_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  option_cfg,
    output logic             global_irq_enable,
    output logic             soft_reset_pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    imro_pkg::imro_state_t          state_q, state_d;
    logic [7:0]                     cmd_q, cmd_d;
    logic [7:0]                     acc_q, acc_d;
    logic [7:0]                     status_q, status_d;
    logic [15:0]                    ptr0_q, ptr0_d;
    logic [15:0]                    ptr1_q, ptr1_d;
    logic [7:0]                     option_q, option_d;
    logic [7:0]                     pwr_q, pwr_d;
    logic [7:0]                     irq_q, irq_d;
    logic [imro_pkg::PC_W-1:0]      pc_q, pc_d;
    logic [31:0]                    prdata_q, prdata_d;
    logic                           pready_q, pready_d;
    logic                           pslverr_q, pslverr_d;
    logic                           srst_q, srst_d;

    logic [7:0]                     mem [imro_pkg::MEM_N];
    logic                           mem_we;
    logic [imro_pkg::MEM_AW-1:0]    mem_waddr;
    logic [7:0]                     mem_wdata;

    logic                           stk_push;
    logic                           stk_pop;
    logic                           stk_flush;
    logic [imro_pkg::PC_W-1:0]      stk_top;
    logic [imro_pkg::SP_W-1:0]      stk_depth;

    logic [15:0]                    sel_ptr;
    logic [15:0]                    ea;
    logic [15:0]                    ptr_next;
    logic [3:0]                     op;
    logic                           access;
    logic                           wr_done;
    logic                           busy;

    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign option_cfg        = option_q;
    assign global_irq_enable = irq_q[imro_pkg::IRQ_EN_BIT];
    assign soft_reset_pulse  = srst_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] zx8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= imro_pkg::OFF_DEPTH);
    endfunction

    assign op      = cmd_q[imro_pkg::CMD_OP_LSB +: 4];
    assign sel_ptr = cmd_q[imro_pkg::CMD_SEL_BIT] ? ptr1_q : ptr0_q;
    assign access  = psel && penable;
    assign wr_done = access && pready_q && pwrite && mapped(paddr);
    assign busy    = (state_q != imro_pkg::ST_IDLE);

    imro_ptr_unit u_ptr (
        .ptr      (sel_ptr),
        .mode     (cmd_q[imro_pkg::CMD_MODE_LSB +: 2]),
        .addr     (ea),
        .ptr_next (ptr_next)
    );

    imro_stack u_stack (
        .clk      (pclk),
        .rst_n    (presetn),
        .push     (stk_push),
        .pop      (stk_pop),
        .flush    (stk_flush),
        .push_val (pwdata[imro_pkg::PC_W-1:0]),
        .top      (stk_top),
        .depth    (stk_depth)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        acc_d     = acc_q;
        status_d  = status_q;
        ptr0_d    = ptr0_q;
        ptr1_d    = ptr1_q;
        option_d  = option_q;
        pwr_d     = pwr_q;
        irq_d     = irq_q;
        pc_d      = pc_q;
        prdata_d  = 32'h00000000;
        pslverr_d = 1'b0;
        pready_d  = access && !pready_q;
        srst_d    = 1'b0;
        mem_we    = 1'b0;
        mem_waddr = '0;
        mem_wdata = 8'h00;
        stk_push  = 1'b0;
        stk_pop   = 1'b0;
        stk_flush = 1'b0;

        // APB read answer in the second access cycle
        if (access && !pready_q) begin
            pslverr_d = !mapped(paddr);
            case (paddr)
                imro_pkg::OFF_CMD: begin
                    prdata_d = {busy, 23'h000000, cmd_q};
                end
                imro_pkg::OFF_ACC:    prdata_d = zx8(acc_q);
                imro_pkg::OFF_STATUS: prdata_d = zx8(status_q);
                imro_pkg::OFF_PTR0:   prdata_d = {16'h0000, ptr0_q};
                imro_pkg::OFF_PTR1:   prdata_d = {16'h0000, ptr1_q};
                imro_pkg::OFF_WIN0:   prdata_d = zx8(mem[ptr0_q[7:0]]); // see RULE2
                imro_pkg::OFF_WIN1:   prdata_d = zx8(mem[ptr1_q[7:0]]); // see RULE2
                imro_pkg::OFF_OPTION: prdata_d = zx8(option_q);
                imro_pkg::OFF_PWR:    prdata_d = zx8(pwr_q);
                imro_pkg::OFF_IRQ:    prdata_d = zx8(irq_q);
                imro_pkg::OFF_PC:     prdata_d = {17'h00000, pc_q};
                imro_pkg::OFF_STACK:  prdata_d = {17'h00000, stk_top};
                imro_pkg::OFF_DEPTH:  prdata_d = {27'h0000000, stk_depth};
                default:              prdata_d = 32'h00000000;
            endcase
        end

        // APB writes take effect at the completing edge
        if (wr_done) begin
            case (paddr)
                imro_pkg::OFF_CMD: begin
                    if (!busy) begin
                        cmd_d   = pwdata[7:0];
                        state_d = imro_pkg::ST_EXEC;
                    end
                end
                imro_pkg::OFF_ACC:    acc_d    = pwdata[7:0];
                imro_pkg::OFF_STATUS: status_d = pwdata[7:0];
                imro_pkg::OFF_PTR0:   ptr0_d   = pwdata[15:0];
                imro_pkg::OFF_PTR1:   ptr1_d   = pwdata[15:0];
                imro_pkg::OFF_WIN0: begin
                    mem_we    = 1'b1; // see RULE2
                    mem_waddr = ptr0_q[7:0];
                    mem_wdata = pwdata[7:0];
                end
                imro_pkg::OFF_WIN1: begin
                    mem_we    = 1'b1; // see RULE2
                    mem_waddr = ptr1_q[7:0];
                    mem_wdata = pwdata[7:0];
                end
                imro_pkg::OFF_OPTION: option_d = pwdata[7:0];
                imro_pkg::OFF_PWR:    pwr_d    = pwdata[7:0];
                imro_pkg::OFF_IRQ:    irq_d    = pwdata[7:0];
                imro_pkg::OFF_PC:     pc_d     = pwdata[imro_pkg::PC_W-1:0];
                imro_pkg::OFF_STACK:  stk_push = 1'b1;
                default: begin
                end
            endcase
        end

        // Instruction sequencer; runs every cycle after the APB write decode and wins when both set a register
        case (state_q)
            imro_pkg::ST_IDLE: begin
            end
            imro_pkg::ST_EXEC: begin
                state_d = imro_pkg::ST_IDLE;
                pc_d    = pc_q + 15'h0001; // see RULE10
                case (op)
                    imro_pkg::OP_WIN_RD: begin
                        acc_d = mem[ea[7:0]]; // see RULE1 see RULE2
                        status_d[imro_pkg::STAT_Z_BIT] = (mem[ea[7:0]] == 8'h00);
                        if (cmd_q[imro_pkg::CMD_SEL_BIT]) begin
                            ptr1_d = ptr_next; // see RULE3 see RULE4
                        end else begin
                            ptr0_d = ptr_next; // see RULE3 see RULE4
                        end
                    end
                    imro_pkg::OP_WIN_WR: begin
                        mem_we    = 1'b1; // see RULE1 see RULE2
                        mem_waddr = ea[7:0];
                        mem_wdata = acc_q;
                        if (cmd_q[imro_pkg::CMD_SEL_BIT]) begin
                            ptr1_d = ptr_next; // see RULE3 see RULE4
                        end else begin
                            ptr0_d = ptr_next; // see RULE3 see RULE4
                        end
                    end
                    imro_pkg::OP_OPTION: begin
                        option_d = acc_q; // see RULE5
                    end
                    imro_pkg::OP_RESET: begin
                        // Core registers except pwr and the window memory return to reset values, see RULE6
                        acc_d     = imro_pkg::ACC_RST;
                        status_d  = imro_pkg::STATUS_RST;
                        ptr0_d    = imro_pkg::PTR_RST;
                        ptr1_d    = imro_pkg::PTR_RST;
                        option_d  = imro_pkg::OPTION_RST;
                        irq_d     = imro_pkg::IRQ_RST;
                        pc_d      = imro_pkg::PC_RST;
                        cmd_d     = 8'h00;
                        stk_flush = 1'b1;
                        srst_d    = 1'b1;
                        pwr_d[imro_pkg::RST_IND_BIT] = 1'b0; // see RULE6
                    end
                    imro_pkg::OP_IRQ_RET: begin
                        stk_pop = 1'b1; // see RULE8
                        pc_d    = stk_top;
                        irq_d[imro_pkg::IRQ_EN_BIT] = 1'b1; // see RULE7
                        state_d = imro_pkg::ST_POP2;
                    end
                    imro_pkg::OP_RETURN: begin
                        stk_pop = 1'b1; // see RULE9
                        pc_d    = stk_top;
                        state_d = imro_pkg::ST_POP2;
                    end
                    default: begin
                    end
                endcase
            end
            imro_pkg::ST_POP2: begin
                state_d = imro_pkg::ST_IDLE; // see RULE8 see RULE9
            end
            default: begin
                state_d = imro_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= imro_pkg::ST_IDLE;
            cmd_q     <= 8'h00;
            acc_q     <= imro_pkg::ACC_RST;
            status_q  <= imro_pkg::STATUS_RST;
            ptr0_q    <= imro_pkg::PTR_RST;
            ptr1_q    <= imro_pkg::PTR_RST;
            option_q  <= imro_pkg::OPTION_RST;
            pwr_q     <= imro_pkg::PWR_RST;
            irq_q     <= imro_pkg::IRQ_RST;
            pc_q      <= imro_pkg::PC_RST;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            srst_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            cmd_q     <= cmd_d;
            acc_q     <= acc_d;
            status_q  <= status_d;
            ptr0_q    <= ptr0_d;
            ptr1_q    <= ptr1_d;
            option_q  <= option_d;
            pwr_q     <= pwr_d;
            irq_q     <= irq_d;
            pc_q      <= pc_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            srst_q    <= srst_d;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

endmodule

// ### dv/imro_core_monitor.sv
// Purpose: Port checks of the indirect move and return block
// Assumes: APB answer after one wait state, registered outputs
// Notes:   Bound into imro_core
module imro_core_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  option_cfg,
    input wire logic        global_irq_enable,
    input wire logic        soft_reset_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;

    ////////////////////////////////////////////////
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    wait_state_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("access phase not two cycles");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    err_unmapped_a: assert property (psel && penable && pready |->
        pslverr == (paddr > 8'h30 || paddr[1:0] != 2'b00))
        else $error("pslverr does not match address map");
    reset_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("software reset pulse too long");
    reset_effect_a: assert property (soft_reset_pulse |->
        ##[0:1] (option_cfg == 8'hFF && !global_irq_enable))
        else $error("software reset left option or enable");
    option_hold_a: assert property (!$stable(option_cfg) |->
        $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("option changed without a write");
    irq_enable_a: assert property ($rose(global_irq_enable) |->
        $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("irq enable rose without a write");
endmodule

bind imro_core imro_core_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .option_cfg(option_cfg),
    .global_irq_enable(global_irq_enable), .soft_reset_pulse(soft_reset_pulse)
);

// ### dv/imro_core_bench.sv
// Purpose: Self-checking bench of the indirect move and return block
// Assumes: APB master tasks, one transfer at a time
// Notes:   Expected values worked out from the operation set
module imro_core_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  option_cfg;
    logic        irq_en;
    logic        srp;
    logic        saw_rst = 1'b0;
    int          error_cnt = 0;
    int          total_checks = 0;

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        if (srp === 1'b1) saw_rst <= 1'b1;
    end

    imro_core i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .option_cfg(option_cfg),
        .global_irq_enable(irq_en), .soft_reset_pulse(srp)
    );

    ////////////////////////////////////////////////
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        @(posedge pclk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic cmd(input logic [3:0] op, input logic [1:0] m, input logic s);
        wreg(imro_pkg::OFF_CMD, {25'h0, s, m, op});
    endtask

    ////////////////////////////////////////////////
    task automatic t_moves();
        logic [15:0] st;
        logic [15:0] nx;
        logic [15:0] ea;
        logic [7:0]  pa;
        wreg(imro_pkg::OFF_STATUS, 32'h03);
        wreg(imro_pkg::OFF_PTR1, 32'h0000);
        wreg(imro_pkg::OFF_WIN1, 32'hA5);
        wreg(imro_pkg::OFF_PTR1, 32'h00FF);
        wreg(imro_pkg::OFF_WIN1, 32'h3C);
        for (int m = 0; m < 4; m++) begin
            st = m[0] ? 16'h0000 : 16'hFFFF;
            nx = m[0] ? st - 16'h1 : st + 16'h1;
            ea = m[1] ? st : nx;
            pa = m[0] ? imro_pkg::OFF_PTR1 : imro_pkg::OFF_PTR0;
            wreg(pa, {16'h0, st});
            cmd(imro_pkg::OP_WIN_RD, m[1:0], m[0]);
            rchk(pa, {16'h0, nx});
            rchk(imro_pkg::OFF_ACC, (ea[7:0] == 8'h00) ? 32'hA5 : 32'h3C);
            rchk(imro_pkg::OFF_STATUS, 32'h03);
        end
        wreg(imro_pkg::OFF_ACC, 32'h0);
        wreg(imro_pkg::OFF_PTR0, 32'h0010);
        cmd(imro_pkg::OP_WIN_WR, imro_pkg::MODE_PRE_INC, 1'b0);
        wreg(imro_pkg::OFF_PTR1, 32'h0011);
        rchk(imro_pkg::OFF_WIN1, 32'h0);
        rchk(imro_pkg::OFF_PTR0, 32'h0011);
        rchk(imro_pkg::OFF_STATUS, 32'h03);
        wreg(imro_pkg::OFF_ACC, 32'h77);
        cmd(imro_pkg::OP_WIN_RD, imro_pkg::MODE_POST_DEC, 1'b1);
        rchk(imro_pkg::OFF_ACC, 32'h0);
        rchk(imro_pkg::OFF_STATUS, 32'h07);
        rchk(imro_pkg::OFF_PTR1, 32'h0010);
    endtask

    task automatic t_option_idle();
        wreg(imro_pkg::OFF_ACC, 32'h5A);
        wreg(imro_pkg::OFF_STATUS, 32'h05);
        cmd(imro_pkg::OP_OPTION, 2'h0, 1'b0);
        rchk(imro_pkg::OFF_OPTION, 32'h5A);
        chk({24'h0, option_cfg}, 32'h5A);
        rchk(imro_pkg::OFF_STATUS, 32'h05);
        wreg(imro_pkg::OFF_PC, 32'h7FFF);
        cmd(imro_pkg::OP_IDLE, 2'h0, 1'b0);
        rchk(imro_pkg::OFF_PC, 32'h0);
        cmd(4'hF, 2'h0, 1'b0);
        rchk(imro_pkg::OFF_PC, 32'h1);
        rchk(imro_pkg::OFF_ACC, 32'h5A);
        rchk(imro_pkg::OFF_STATUS, 32'h05);
    endtask

    task automatic t_returns();
        wreg(imro_pkg::OFF_IRQ, 32'h0);
        wreg(imro_pkg::OFF_STACK, 32'h0123);
        wreg(imro_pkg::OFF_STACK, 32'h4567);
        rchk(imro_pkg::OFF_DEPTH, 32'h2);
        cmd(imro_pkg::OP_IRQ_RET, 2'h0, 1'b0);
        rchk(imro_pkg::OFF_PC, 32'h4567);
        rchk(imro_pkg::OFF_IRQ, 32'h80);
        chk({31'h0, irq_en}, 32'h1);
        rchk(imro_pkg::OFF_DEPTH, 32'h1);
        cmd(imro_pkg::OP_RETURN, 2'h0, 1'b0);
        cmd(imro_pkg::OP_IDLE, 2'h0, 1'b0);
        rchk(imro_pkg::OFF_PC, 32'h0124);
        rchk(imro_pkg::OFF_DEPTH, 32'h0);
        rchk(imro_pkg::OFF_STATUS, 32'h05);
    endtask

    task automatic t_soft_reset();
        logic [31:0] r;
        logic        e;
        rchk(imro_pkg::OFF_PWR, 32'h04);
        saw_rst = 1'b0;
        wreg(imro_pkg::OFF_PTR0, 32'h1234);
        cmd(imro_pkg::OP_RESET, 2'h0, 1'b0);
        rchk(imro_pkg::OFF_PWR, 32'h0);
        chk({31'h0, saw_rst}, 32'h1);
        rchk(imro_pkg::OFF_OPTION, 32'hFF);
        rchk(imro_pkg::OFF_PTR0, 32'h0);
        chk({31'h0, irq_en}, 32'h0);
        xfer(1'b0, 8'h34, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        xfer(1'b1, 8'h06, 32'hFF, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    ////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({24'h0, option_cfg}, 32'hFF);
        t_moves();
        t_option_idle();
        t_returns();
        t_soft_reset();
        stop_test();
    end
endmodule
